// file: hw/durb_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module durb_baud_gen
(
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic [durb_pkg::DIV_W-1:0] baud_divisor,
	durb_tick_if.source                     tick
);

	logic [durb_pkg::DIV_W-1:0] cnt_q;
	logic [durb_pkg::DIV_W-1:0] cnt_d;
	logic [3:0]                 sub_q;
	logic [3:0]                 sub_d;
	logic                       s_tick_q;
	logic                       s_tick_d;
	logic                       b_tick_q;
	logic                       b_tick_d;
	logic                       act_q;
	logic                       act_d;

	//==========================================================
	// Divider
	always_comb
	begin
		cnt_d    = cnt_q;
		sub_d    = sub_q;
		s_tick_d = 1'b0;
		b_tick_d = 1'b0;
		act_d    = 1'b1;
		if (baud_divisor == '0)
		begin
			cnt_d = '0;
			sub_d = '0;
			act_d = 1'b0;
		end
		else if (cnt_q >= baud_divisor - 16'h0001)
		begin
			cnt_d    = '0;
			s_tick_d = 1'b1;
			sub_d    = sub_q + 4'h1;
			b_tick_d = (sub_q == durb_pkg::OVERSAMPLE_MAX);
		end
		else
		begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_q    <= '0;
			sub_q    <= '0;
			s_tick_q <= 1'b0;
			b_tick_q <= 1'b0;
			act_q    <= 1'b0;
		end
		else
		begin
			cnt_q    <= cnt_d;
			sub_q    <= sub_d;
			s_tick_q <= s_tick_d;
			b_tick_q <= b_tick_d;
			act_q    <= act_d;
		end
	end

	assign tick.sample_tick = s_tick_q;
	assign tick.baud_tick   = b_tick_q;
	assign tick.active      = act_q;

	//==========================================================
	// Checks
	a_div_zero_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		$past(baud_divisor == '0) |-> (!s_tick_q && !act_q))
		else $error("sample tick while divisor is zero");

	a_baud_on_sample: assert property (@(posedge clock) disable iff (!rst_n)
		b_tick_q |-> s_tick_q)
		else $error("baud tick without sample tick");

	a_div_one_rate: assert property (@(posedge clock) disable iff (!rst_n)
		(baud_divisor == 16'h0001) [*2] |=> s_tick_q)
		else $error("divisor one must tick every cycle");

	c_baud_tick: cover property (@(posedge clock) disable iff (!rst_n) b_tick_q);

endmodule
`default_nettype wire

// file: hw/durb_pkg.sv
`default_nettype none
package durb_pkg;

	//==========================================================
	// Baud generator
	localparam int          DIV_W         = 16;
	localparam logic [15:0] DIV_RESET     = 16'h0000;
	localparam logic [3:0]  OVERSAMPLE_MAX = 4'hF;

	//==========================================================
	// Receiver timing in sampling ticks, then data bit count and last bit index
	localparam logic [4:0] BIT_TICKS      = 5'h10;
	localparam logic [4:0] START_LOW_MIN  = 5'h07;
	localparam logic [4:0] FIRST_SAMPLE   = 5'h18;
	localparam int         DATA_BITS      = 8;
	localparam logic [2:0] LAST_BIT       = 3'h7;

	//==========================================================
	// Parity mode field: bit 2 set means no parity bit
	localparam logic [2:0] PAR_EVEN  = 3'h0;
	localparam logic [2:0] PAR_ODD   = 3'h1;
	localparam logic [2:0] PAR_SPACE = 3'h2;
	localparam logic [2:0] PAR_MARK  = 3'h3;
	localparam int         PAR_NONE_POS = 2;

	//==========================================================
	// Reset values
	localparam logic [7:0] HOLD_RESET = 8'h00;
	localparam logic       RX_EN_RESET = 1'b0;

	typedef enum logic [2:0] {
		DURB_IDLE,
		DURB_START,
		DURB_DATA,
		DURB_PARITY,
		DURB_STOP
	} durb_rx_state_t;

	function automatic logic durb_parity_bit(input logic [7:0] data, input logic [2:0] mode);
		logic res;
		res = 1'b0;
		unique case (mode[1:0])
			PAR_EVEN[1:0]:  res = ^data;
			PAR_ODD[1:0]:   res = ~(^data);
			PAR_SPACE[1:0]: res = 1'b0;
			PAR_MARK[1:0]:  res = 1'b1;
		endcase
		return res;
	endfunction

endpackage
`default_nettype wire

// file: hw/durb_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface durb_tick_if;
	logic sample_tick;
	logic baud_tick;
	logic active;
	modport source (output sample_tick, output baud_tick, output active);
	modport sink   (input sample_tick, input baud_tick, input active);
endinterface
`default_nettype wire

// file: hw/durb_top.sv
`timescale 1ns/10ps
`default_nettype none
module durb_top
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        serial_rx_pin,
	output var  logic        serial_tx_pin,
	input  wire logic [15:0] baud_divisor,
	input  wire logic [2:0]  parity_mode_field,
	input  wire logic        rx_enable_cmd,
	input  wire logic        rx_disable_cmd,
	input  wire logic        rx_reset_cmd,
	input  wire logic        clear_status_cmd,
	input  wire logic        rx_holding_read,
	output var  logic [7:0]  rx_holding_register,
	output var  logic        rx_char_ready,
	output var  logic        rx_overrun_flag,
	output var  logic        parity_error_flag,
	output var  logic        framing_error_flag,
	output var  logic        rx_enabled,
	output var  logic        baud_tick,
	input  wire logic        dcc_read_full,
	input  wire logic        dcc_write_full,
	input  wire logic        dcc_read_irq_en,
	input  wire logic        dcc_write_irq_en,
	output var  logic        dcc_read_full_status,
	output var  logic        dcc_write_full_status,
	output var  logic        dcc_irq,
	input  wire logic        force_test_reset_bit,
	output var  logic        emu_test_reset_n
);

	durb_tick_if tick ();

	durb_baud_gen u_baud
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.baud_divisor (baud_divisor),
		.tick         (tick.source)
	);

	//==========================================================
	// Input synchronisers
	logic rx_s1_q;
	logic rx_s2_q;
	logic [1:0] dcc_s1_q;
	logic [1:0] dcc_s2_q;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rx_s1_q  <= 1'b1;
			rx_s2_q  <= 1'b1;
			dcc_s1_q <= 2'h0;
			dcc_s2_q <= 2'h0;
		end
		else
		begin
			rx_s1_q  <= serial_rx_pin;
			rx_s2_q  <= rx_s1_q;
			dcc_s1_q <= {dcc_write_full, dcc_read_full};
			dcc_s2_q <= dcc_s1_q;
		end
	end

	//==========================================================
	// Receiver state machine
	durb_pkg::durb_rx_state_t st_q;
	durb_pkg::durb_rx_state_t st_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [2:0] bit_q;
	logic [2:0] bit_d;
	logic [7:0] shf_q;
	logic [7:0] shf_d;
	logic       en_q;
	logic       en_d;
	logic       par_bad_q;
	logic       par_bad_d;
	logic       done;
	logic       stop_ok;
	logic       use_par;

	assign use_par = !parity_mode_field[durb_pkg::PAR_NONE_POS];

	always_comb
	begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		bit_d     = bit_q;
		shf_d     = shf_q;
		en_d      = en_q;
		par_bad_d = par_bad_q;
		done      = 1'b0;
		stop_ok   = 1'b1;
		if (rx_enable_cmd)
			en_d = 1'b1;
		if (rx_disable_cmd)
			en_d = 1'b0;
		if (tick.sample_tick)
		begin
			unique case (st_q)
				durb_pkg::DURB_IDLE:
				begin
					if (en_q && !rx_s2_q)
					begin
						st_d  = durb_pkg::DURB_START;
						cnt_d = 5'h00;
					end
				end
				durb_pkg::DURB_START:
				begin
					if (cnt_q < durb_pkg::START_LOW_MIN && (rx_s2_q || !en_q))
						st_d = durb_pkg::DURB_IDLE;
					else if (cnt_q == durb_pkg::FIRST_SAMPLE - 5'h01)
					begin
						shf_d = {rx_s2_q, shf_q[7:1]};
						bit_d = 3'h1;
						cnt_d = 5'h00;
						st_d  = durb_pkg::DURB_DATA;
					end
					else
						cnt_d = cnt_q + 5'h01;
				end
				durb_pkg::DURB_DATA, durb_pkg::DURB_PARITY, durb_pkg::DURB_STOP:
				begin
					if (cnt_q == durb_pkg::BIT_TICKS - 5'h01)
					begin
						cnt_d = 5'h00;
						unique case (st_q)
							durb_pkg::DURB_DATA:
							begin
								shf_d = {rx_s2_q, shf_q[7:1]};
								bit_d = bit_q + 3'h1;
								if (bit_q == durb_pkg::LAST_BIT)
									st_d = use_par ? durb_pkg::DURB_PARITY : durb_pkg::DURB_STOP;
							end
							durb_pkg::DURB_PARITY:
							begin
								par_bad_d = rx_s2_q != durb_pkg::durb_parity_bit(shf_q, parity_mode_field);
								st_d      = durb_pkg::DURB_STOP;
							end
							default:
							begin
								done    = 1'b1;
								stop_ok = rx_s2_q;
								st_d    = durb_pkg::DURB_IDLE;
							end
						endcase
					end
					else
						cnt_d = cnt_q + 5'h01;
				end
			endcase
		end
		if (st_d == durb_pkg::DURB_IDLE)
			par_bad_d = 1'b0;
		if (rx_reset_cmd)
		begin
			st_d      = durb_pkg::DURB_IDLE;
			en_d      = 1'b0;
			done      = 1'b0;
			par_bad_d = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_q      <= durb_pkg::DURB_IDLE;
			cnt_q     <= 5'h00;
			bit_q     <= 3'h0;
			shf_q     <= durb_pkg::HOLD_RESET;
			en_q      <= durb_pkg::RX_EN_RESET;
			par_bad_q <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			bit_q     <= bit_d;
			shf_q     <= shf_d;
			en_q      <= en_d;
			par_bad_q <= par_bad_d;
		end
	end

	//==========================================================
	// Holding register and status flags
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	logic       rdy_q;
	logic       rdy_d;
	logic       ovr_q;
	logic       ovr_d;
	logic       pe_q;
	logic       pe_d;
	logic       fe_q;
	logic       fe_d;

	// Set wins over a same-cycle read or clear, so no event is lost
	always_comb
	begin
		hold_d = hold_q;
		rdy_d  = rdy_q;
		ovr_d  = ovr_q;
		pe_d   = pe_q;
		fe_d   = fe_q;
		if (rx_holding_read)
			rdy_d = 1'b0;
		if (clear_status_cmd)
		begin
			ovr_d = 1'b0;
			pe_d  = 1'b0;
			fe_d  = 1'b0;
		end
		if (done)
		begin
			hold_d = shf_q;
			rdy_d  = 1'b1;
			if (rdy_q && !rx_holding_read)
				ovr_d = 1'b1;
			if (par_bad_q)
				pe_d = 1'b1;
			if (!stop_ok)
				fe_d = 1'b1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			hold_q <= durb_pkg::HOLD_RESET;
			rdy_q  <= 1'b0;
			ovr_q  <= 1'b0;
			pe_q   <= 1'b0;
			fe_q   <= 1'b0;
		end
		else
		begin
			hold_q <= hold_d;
			rdy_q  <= rdy_d;
			ovr_q  <= ovr_d;
			pe_q   <= pe_d;
			fe_q   <= fe_d;
		end
	end

	//==========================================================
	// Debug channel, test reset, transmit idle, baud tick out
	logic [1:0] dcc_q;
	logic       irq_q;
	logic       ftr_q;
	logic       btk_q;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			dcc_q <= 2'h0;
			irq_q <= 1'b0;
			ftr_q <= 1'b1;
			btk_q <= 1'b0;
		end
		else
		begin
			dcc_q <= dcc_s2_q;
			irq_q <= (dcc_s2_q[0] && dcc_read_irq_en) || (dcc_s2_q[1] && dcc_write_irq_en);
			ftr_q <= !force_test_reset_bit;
			// transmitter side of the shared tick
			btk_q <= tick.baud_tick;
		end
	end

	// Transmitter lives elsewhere; the line idles at mark
	assign serial_tx_pin         = 1'b1;
	assign rx_holding_register   = hold_q;
	assign rx_char_ready         = rdy_q;
	assign rx_overrun_flag       = ovr_q;
	assign parity_error_flag     = pe_q;
	assign framing_error_flag    = fe_q;
	assign rx_enabled            = en_q;
	assign baud_tick             = btk_q;
	assign dcc_read_full_status  = dcc_q[0];
	assign dcc_write_full_status = dcc_q[1];
	assign dcc_irq               = irq_q;
	assign emu_test_reset_n      = ftr_q;

	//==========================================================
	// Checks
	a_reset_disabled: assert property (@(posedge clock)
		$past(!rst_n) |-> !en_q)
		else $error("receiver enabled after reset");

	a_enable_cmd: assert property (@(posedge clock) disable iff (!rst_n)
		(rx_enable_cmd && !rx_disable_cmd && !rx_reset_cmd) |=> en_q)
		else $error("enable command ignored");

	a_rx_reset_abort: assert property (@(posedge clock) disable iff (!rst_n)
		rx_reset_cmd |=> (st_q == durb_pkg::DURB_IDLE && !en_q))
		else $error("receiver reset did not abort");

	a_idle_disabled: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == durb_pkg::DURB_IDLE && !en_q) |=> st_q == durb_pkg::DURB_IDLE)
		else $error("disabled receiver left idle");

	a_glitch_reject: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == durb_pkg::DURB_START && tick.sample_tick && cnt_q < 5'h07 && rx_s2_q && !rx_reset_cmd)
		|=> st_q == durb_pkg::DURB_IDLE)
		else $error("glitch accepted as start");

	a_first_sample: assert property (@(posedge clock) disable iff (!rst_n)
		(st_q == durb_pkg::DURB_START && $past(st_q) == durb_pkg::DURB_IDLE) |-> cnt_q == 5'h00)
		else $error("start count not cleared at edge");

	a_ready_on_char: assert property (@(posedge clock) disable iff (!rst_n)
		done |=> (rdy_q && hold_q == $past(shf_q)))
		else $error("character not loaded");

	a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
		(rx_holding_read && !done) |=> !rdy_q)
		else $error("read did not clear ready");

	a_overrun_set: assert property (@(posedge clock) disable iff (!rst_n)
		(done && rdy_q && !rx_holding_read) |=> ovr_q)
		else $error("overrun missed");

	a_frame_set: assert property (@(posedge clock) disable iff (!rst_n)
		(done && !stop_ok) |=> fe_q ##1 (fe_q || $past(clear_status_cmd)))
		else $error("framing error missed or dropped");

	a_test_reset: assert property (@(posedge clock) disable iff (!rst_n)
		force_test_reset_bit |=> !emu_test_reset_n)
		else $error("test reset not forced");

	c_char_done: cover property (@(posedge clock) disable iff (!rst_n) done && stop_ok);
	c_glitch: cover property (@(posedge clock) disable iff (!rst_n)
		st_q == durb_pkg::DURB_START ##1 st_q == durb_pkg::DURB_IDLE);
	c_overrun: cover property (@(posedge clock) disable iff (!rst_n) $rose(ovr_q));
	c_parity: cover property (@(posedge clock) disable iff (!rst_n) $rose(pe_q));

endmodule
`default_nettype wire

// file: sim/durb_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module durb_tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        rx_line;
	logic [15:0] div   = 16'h0002;
	logic [2:0]  mode  = 3'h4;
	logic [4:0]  cmdv  = 5'h00;
	logic [1:0]  full  = 2'h0;
	logic [1:0]  ien   = 2'h0;
	logic        frc   = 1'b0;
	logic [7:0]  hold;
	logic        rdy, ovr, perr, ferr, en, btick, tx, rst_st, wst_st, irq, emu_n;
	int          n_errors = 0;
	int          checked  = 0;
	int          k;
	logic [7:0]  d;

	always #5 clock = ~clock;

	durb_term_model durb_term_model_inst (.clock(clock), .line(rx_line));

	durb_top durb_top_inst (.clock(clock), .rst_n(rst_n), .serial_rx_pin(rx_line), .serial_tx_pin(tx),
		.baud_divisor(div), .parity_mode_field(mode), .rx_enable_cmd(cmdv[4]), .rx_disable_cmd(cmdv[3]),
		.rx_reset_cmd(cmdv[2]), .clear_status_cmd(cmdv[1]), .rx_holding_read(cmdv[0]),
		.rx_holding_register(hold), .rx_char_ready(rdy), .rx_overrun_flag(ovr), .parity_error_flag(perr),
		.framing_error_flag(ferr), .rx_enabled(en), .baud_tick(btick), .dcc_read_full(full[1]),
		.dcc_write_full(full[0]), .dcc_read_irq_en(ien[1]), .dcc_write_irq_en(ien[0]),
		.dcc_read_full_status(rst_st), .dcc_write_full_status(wst_st), .dcc_irq(irq),
		.force_test_reset_bit(frc), .emu_test_reset_n(emu_n));

	//==========================================================
	// Helpers
	function automatic logic exp_par(input logic [7:0] v, input logic [2:0] m);
		case (m[1:0])
			2'h0: return ^v;
			2'h1: return ~(^v);
			2'h2: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Order: enable, disable, reset, clear, read
	task automatic cmd(input logic [4:0] m);
		@(posedge clock);
		cmdv <= m;
		@(posedge clock);
		cmdv <= 5'h00;
		#1;
	endtask

	task automatic frame(input logic [7:0] v, input logic pbad, input logic stp);
		durb_term_model_inst.send(v, {~mode[2], exp_par(v, mode) ^ pbad}, stp, 16 * int'(div));
	endtask

	// Bounded wait, ready is set near mid stop bit
	task automatic wait_rdy(input logic e);
		k = 0;
		while (rdy !== 1'b1 && k < 64)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		chk("ready", {15'h0, e}, {15'h0, rdy});
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clock);
		n_errors++;
		close_out;
	end

	//==========================================================
	// Tests
	initial
	begin
		void'($urandom(32'h605B));
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk("enabled", 16'h0000, {15'h0, en});
		chk("flags", 16'h0000, {12'h0, rdy, ovr, perr, ferr});
		chk("tx", 16'h0001, {15'h0, tx});
		frame(8'h5A, 1'b0, 1'b1);
		wait_rdy(1'b0);
		cmd(5'h10);
		chk("enabled", 16'h0001, {15'h0, en});
		$display("test reset done");
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clock);
			div <= 16'($urandom_range(1, 3));
			mode <= 3'(i % 5);
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			// Let the new divisor and mode settle before the frame reads them
			#1;
			frame(d, 1'b0, 1'b1);
			wait_rdy(1'b1);
			chk("holding", {8'h0, d}, {8'h0, hold});
			chk("perr", 16'h0000, {15'h0, perr});
			chk("ferr", 16'h0000, {15'h0, ferr});
			cmd(5'h01);
			chk("ready", 16'h0000, {15'h0, rdy});
		end
		$display("test random done");
		mode <= 3'h1;
		frame(8'hA5, 1'b1, 1'b1);
		wait_rdy(1'b1);
		chk("perr", 16'h0001, {15'h0, perr});
		cmd(5'h01);
		frame(8'h3C, 1'b0, 1'b0);
		wait_rdy(1'b1);
		chk("perr", 16'h0001, {15'h0, perr});
		chk("ferr", 16'h0001, {15'h0, ferr});
		cmd(5'h03);
		chk("flags", 16'h0000, {13'h0, rdy, perr, ferr});
		frame(8'h11, 1'b0, 1'b1);
		frame(8'h22, 1'b0, 1'b1);
		wait_rdy(1'b1);
		chk("ovr", 16'h0001, {15'h0, ovr});
		chk("holding", 16'h0022, {8'h0, hold});
		cmd(5'h03);
		chk("ovr", 16'h0000, {15'h0, ovr});
		$display("test errors done");
		fork
			frame(8'h96, 1'b0, 1'b1);
			begin
				repeat (64) @(posedge clock);
				cmd(5'h08);
			end
		join
		wait_rdy(1'b1);
		chk("holding", 16'h0096, {8'h0, hold});
		chk("enabled", 16'h0000, {15'h0, en});
		cmd(5'h11);
		fork
			frame(8'h69, 1'b0, 1'b1);
			begin
				repeat (64) @(posedge clock);
				cmd(5'h04);
			end
		join
		wait_rdy(1'b0);
		chk("enabled", 16'h0000, {15'h0, en});
		cmd(5'h10);
		cmd(5'h08);
		chk("enabled", 16'h0000, {15'h0, en});
		$display("test disable done");
		cmd(5'h10);
		div <= 16'h0001;
		mode <= 3'h4;
		durb_term_model_inst.glitch(7);
		repeat (300) @(posedge clock);
		wait_rdy(1'b0);
		durb_term_model_inst.glitch(8);
		repeat (200) @(posedge clock);
		wait_rdy(1'b1);
		chk("holding", 16'h00FF, {8'h0, hold});
		$display("test start done");
		div <= 16'h0003;
		k = 0;
		while (btick !== 1'b1 && k < 100)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		k = 0;
		do
		begin
			@(posedge clock);
			#1;
			k++;
		end while (btick !== 1'b1 && k < 100);
		chk("tick gap", 16'd48, 16'(k));
		@(posedge clock);
		div <= 16'h0000;
		k = 0;
		repeat (200)
		begin
			@(posedge clock);
			#1;
			if (btick === 1'b1)
				k++;
		end
		chk("ticks", 16'h0000, 16'(k));
		$display("test baud done");
		@(posedge clock);
		full <= 2'h3;
		ien <= 2'h2;
		frc <= 1'b1;
		repeat (5) @(posedge clock);
		#1;
		chk("dcc", 16'h0007, {13'h0, rst_st, wst_st, irq});
		chk("emu", 16'h0000, {15'h0, emu_n});
		full <= 2'h1;
		frc <= 1'b0;
		repeat (5) @(posedge clock);
		#1;
		// software polls each sharer's status bits
		chk("dcc", 16'h0002, {13'h0, rst_st, wst_st, irq});
		chk("emu", 16'h0001, {15'h0, emu_n});
		$display("test dcc done");
		close_out;
	end
endmodule
`default_nettype wire

// file: sim/durb_term_model.sv
`timescale 1ns/10ps
`default_nettype none
module durb_term_model
(
	input  wire logic clock,
	output var  logic line
);
	//==========================================================
	// Remote terminal, idle high between frames
	initial line = 1'b1;

	task automatic send(input logic [7:0] d, input logic [1:0] par, input logic stp, input int bc);
		logic [10:0] f;
		int          n;
		f = {stp, par[0], d, 1'b0};
		n = par[1] ? 11 : 10;
		if (!par[1])
			f[9] = stp;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock);
			line <= f[i];
			repeat (bc - 1) @(posedge clock);
		end
		@(posedge clock);
		line <= 1'b1;
	endtask

	// Short low pulse, no frame behind it
	task automatic glitch(input int c);
		@(posedge clock);
		line <= 1'b0;
		repeat (c) @(posedge clock);
		line <= 1'b1;
	endtask
endmodule
`default_nettype wire
